// file: common/qspic_pkg.sv
// package for the queued serial master control block: register map, fields, timing
// assumes a 10 MHz system clock and a 32-bit apb register bus
package qspic_pkg;

  // register byte offsets
  localparam logic [7:0] MODE_OFS      = 8'h00; // serial_mode_config
  localparam logic [7:0] DELAY_OFS     = 8'h04; // serial_delay_enable
  localparam logic [7:0] WRAP_OFS      = 8'h08; // queue_wrap_pointers
  localparam logic [7:0] RAM_IDX_OFS   = 8'h0C; // ram_index_reg
  localparam logic [7:0] RAM_WIN_OFS   = 8'h10; // ram_window_reg

  // mode register fields
  localparam int MASTER_BIT       = 15;
  localparam int DOUT_TRI_BIT     = 14;
  localparam int BITS_LSB         = 10;
  localparam int CPOL_BIT         = 9;
  localparam int CPHA_BIT         = 8;
  localparam int BAUD_LSB         = 0;
  // delay register fields
  localparam int RUN_BIT          = 15;
  localparam int QCD_LSB          = 8;
  localparam int DTL_LSB          = 0;
  // wrap register fields
  localparam int HALT_BIT         = 15;
  localparam int WRAP_ON_BIT      = 14;
  localparam int WRAP_TGT_BIT     = 13;
  localparam int CS_IDLE_BIT      = 12;
  localparam int END_LSB          = 8;
  localparam int DONE_LSB         = 4;
  localparam int START_LSB        = 0;

  // reset values
  localparam logic [15:0] MODE_RST  = 16'h0000;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] WRAP_RST  = 16'h0000;

  // queue storage: 16 tx words, 16 rx words, 16 command bytes = 80 bytes
  localparam int RAM_ENTRIES      = 16;
  localparam logic [6:0] TX_BASE  = 7'h00;
  localparam logic [6:0] RX_BASE  = 7'h10;
  localparam logic [6:0] CMD_BASE = 7'h20;
  localparam logic [6:0] RAM_TOP  = 7'h30;

  // command byte fields
  localparam int CMD_CONT_BIT     = 7;
  localparam int CMD_BITSE_BIT    = 6;
  localparam int CMD_DT_BIT       = 5;
  localparam int CMD_SELECT_DELAY_ON_BIT     = 4;

  // timing
  localparam int SYS_CLK_HZ       = 10_000_000;
  localparam int STD_POST_CYC     = 17;      // standard after-transfer delay
  localparam int POST_MULT        = 32;      // programmed after-transfer scale
  localparam int POST_ZERO_CYC    = 8192;    // after-transfer delay for a zero field
  localparam int DEFAULT_BITS     = 8;       // length when per-command length is off

  // serial pin group
  typedef struct packed {
    logic       sck;
    logic       dout;
    logic       dout_oe_n;
    logic [3:0] cs;
  } qspic_pins_t;

  typedef enum logic [2:0] {
    IDLE, LEAD, SHIFT, POST, NEXT
  } qspic_state_t;

endpackage

// file: design/qspic_ctrl.sv
// queued serial-peripheral master: control registers, queue sequencer and shifter
// assumes an apb master on clk_in, 16-bit meaningful data, serial peripherals on the pins
module qspic_ctrl
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        din_in,
  input  wire logic        abort_lockout_in,
  output qspic_pkg::qspic_pins_t pins_out
);

  // register storage
  logic [15:0] mode_ff;                // serial_mode_config
  logic [14:0] dly_ff;                 // delay fields of serial_delay_enable
  logic        run_ff;                 // queue_run
  logic [15:0] wrap_ff;                // queue_wrap_pointers, done field unused here
  logic [3:0]  done_ptr_ff;            // queue_done_ptr
  logic [6:0]  ram_idx_ff;             // ram_index_reg
  logic [15:0] ram_ff [0:47];          // tx, rx and command words
  logic        din_s1_ff;              // synchroniser stage one
  logic        din_s2_ff;              // synchroniser stage two
  qspic_pkg::qspic_state_t state_ff;   // sequencer state
  logic [3:0]  qp_ff;                  // working queue pointer
  logic [13:0] wait_ff;                // delay counter
  logic [7:0]  div_ff;                 // baud prescaler
  logic [4:0]  edge_ff;                // sample edges left
  logic [15:0] shreg_ff;               // shift register
  logic        sck_ff;                 // serial clock level
  logic        dout_ff;                // data out level
  logic        dout_oe_n_ff;           // data out enable, low drives
  logic [3:0]  cs_ff;                  // select levels
  logic        stop_req_ff;            // halt latched for this command

  logic        wr_acc;                 // apb write access cycle
  logic        rd_acc;                 // apb read access cycle
  logic        half_tick;              // one half serial clock period elapsed
  logic [15:0] cmd_w;                  // current command byte
  logic [4:0]  nbits;                  // bits this entry
  logic        sw_clear_run;           // software abort request
  logic        done_cmd;               // post delay finished
  logic [13:0] lead_w;                 // system clock cycles from select to first edge

  // field decode used by the shifter through nbits
  function automatic logic [4:0] bits_of(input logic [3:0] code, input logic use_field);
    if (!use_field)
      bits_of = 5'(qspic_pkg::DEFAULT_BITS);
    else if (code == 4'h0)
      bits_of = 5'h10;
    else
      bits_of = {1'b0, code};                      // reserved codes 1-7 pass through
  endfunction

  assign wr_acc       = psel_in && penable_in && pwrite_in;
  assign rd_acc       = psel_in && penable_in && !pwrite_in;
  assign cmd_w        = ram_ff[6'(qspic_pkg::CMD_BASE) + 6'(qp_ff)];
  assign nbits        = bits_of(mode_ff[qspic_pkg::BITS_LSB +: 4], cmd_w[qspic_pkg::CMD_BITSE_BIT]);
  // baud zero freezes the prescaler, so no serial clock ever runs
  assign half_tick    = (mode_ff[7:0] != 8'h00) && (div_ff == 8'h01);
  assign sw_clear_run = wr_acc && (paddr_in == qspic_pkg::DELAY_OFS)
                        && !pwdata_in[qspic_pkg::RUN_BIT] && !abort_lockout_in;
  assign done_cmd     = (state_ff == qspic_pkg::POST) && (wait_ff == 14'h0001);
  // lead length: programmed field when the command asks for it and the field is non-zero, else half a serial period
  assign lead_w       = (cmd_w[qspic_pkg::CMD_SELECT_DELAY_ON_BIT] && dly_ff[14:8] != 7'h00)
                        ? {7'h00, dly_ff[14:8]} : {6'h00, mode_ff[7:0]};

  // apb answers in the access cycle, never stalls
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= psel_in && !penable_in;
      // addresses above the ram window answer with an error
      pslverr_out <= psel_in && !penable_in && (paddr_in > qspic_pkg::RAM_WIN_OFS);
    end
  end

  // read data mux, registered from the setup cycle
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      prdata_out <= 32'h0000_0000;
    else if (psel_in && !penable_in && !pwrite_in)
    begin
      unique case (paddr_in)
        qspic_pkg::MODE_OFS:    prdata_out <= {16'h0000, mode_ff};
        qspic_pkg::DELAY_OFS:   prdata_out <= {16'h0000, run_ff, dly_ff};
        qspic_pkg::WRAP_OFS:    prdata_out <= {16'h0000, wrap_ff[15:8], done_ptr_ff, wrap_ff[3:0]};
        qspic_pkg::RAM_IDX_OFS: prdata_out <= {25'h0000000, ram_idx_ff};
        qspic_pkg::RAM_WIN_OFS: prdata_out <= (ram_idx_ff < qspic_pkg::RAM_TOP)
                                              ? {16'h0000, ram_ff[6'(ram_idx_ff)]} : 32'h0000_0000;
        default:                prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // mode, delay and wrap control fields
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      mode_ff <= qspic_pkg::MODE_RST;
      wrap_ff <= qspic_pkg::WRAP_RST;
      dly_ff  <= qspic_pkg::DELAY_RST[14:0];
    end
    else if (wr_acc)
    begin
      // master bit is stored only; the block is master regardless
      if (paddr_in == qspic_pkg::MODE_OFS)
        mode_ff <= pwdata_in[15:0];
      if (paddr_in == qspic_pkg::DELAY_OFS)
        dly_ff <= pwdata_in[14:0];
      if (paddr_in == qspic_pkg::WRAP_OFS)
        wrap_ff <= pwdata_in[15:0];
    end
  end

  // run bit: software sets, hardware clears at queue end
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      run_ff <= 1'b0;
    else if (wr_acc && (paddr_in == qspic_pkg::DELAY_OFS) && pwdata_in[qspic_pkg::RUN_BIT])
      run_ff <= 1'b1;
    else if (sw_clear_run)
      run_ff <= 1'b0;
    else if (state_ff == qspic_pkg::NEXT && (stop_req_ff
             || (qp_ff == wrap_ff[qspic_pkg::END_LSB +: 4] && !wrap_ff[qspic_pkg::WRAP_ON_BIT])))
      run_ff <= 1'b0;
  end

  // index register and window access to the queue storage
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      ram_idx_ff <= 7'h00;
    else if (wr_acc && paddr_in == qspic_pkg::RAM_IDX_OFS)
      ram_idx_ff <= pwdata_in[6:0];
    else if ((wr_acc || rd_acc) && paddr_in == qspic_pkg::RAM_WIN_OFS && ram_idx_ff < qspic_pkg::RAM_TOP)
      ram_idx_ff <= ram_idx_ff + 7'h01;            // auto increment eases block fills
  end

  // storage writes: software through window, receive data from the shifter
  always_ff @(posedge clk_in)
  begin
    if (wr_acc && paddr_in == qspic_pkg::RAM_WIN_OFS && ram_idx_ff < qspic_pkg::RAM_TOP)
      ram_ff[6'(ram_idx_ff)] <= pwdata_in[15:0];
    else if (state_ff == qspic_pkg::SHIFT && edge_ff == 5'h00)
      ram_ff[6'(qspic_pkg::RX_BASE) + 6'(qp_ff)] <= shreg_ff;
  end

  // input synchroniser
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end
    else
    begin
      din_s1_ff <= din_in;
      din_s2_ff <= din_s1_ff;
    end
  end

  // baud prescaler, one tick every baud cycles
  // primed outside shift so the first edge fires on the first shift cycle; keeps the lead exact
  always_ff @(posedge clk_in)
  begin
    if (srst_in || state_ff != qspic_pkg::SHIFT)
      div_ff <= 8'h01;
    else if (div_ff == 8'h01)
      div_ff <= mode_ff[7:0];
    else if (div_ff != 8'h00)
      div_ff <= div_ff - 8'h01;
  end

  // queue sequencer
  always_ff @(posedge clk_in)
  begin
    if (srst_in || sw_clear_run)
    begin
      state_ff    <= qspic_pkg::IDLE;              // abort drops the transfer at once
      qp_ff       <= 4'h0;
      wait_ff     <= 14'h0000;
      stop_req_ff <= 1'b0;
      if (srst_in)
        done_ptr_ff <= 4'h0;
    end
    else
    begin
      if (wrap_ff[qspic_pkg::HALT_BIT] && state_ff != qspic_pkg::IDLE)
        stop_req_ff <= 1'b1;
      unique case (state_ff)
        qspic_pkg::IDLE:
        begin
          stop_req_ff <= 1'b0;
          if (run_ff && !wrap_ff[qspic_pkg::HALT_BIT])
          begin
            qp_ff   <= wrap_ff[qspic_pkg::START_LSB +: 4];
            state_ff <= qspic_pkg::LEAD;
            wait_ff  <= 14'h0000;
          end
        end
        qspic_pkg::LEAD:
        begin
          // lead delay counted while selects are active
          // leave one cycle early: the first serial edge comes on the first shift cycle
          if (wait_ff == 14'h0000)
          begin
            wait_ff <= lead_w;
            if (lead_w == 14'h0001)
              state_ff <= qspic_pkg::SHIFT;        // one-cycle lead
          end
          else if (wait_ff == 14'h0002)
          begin
            state_ff <= qspic_pkg::SHIFT;
            wait_ff  <= 14'h0000;
          end
          else
            wait_ff <= wait_ff - 14'h0001;
        end
        qspic_pkg::SHIFT:
        begin
          // every bit sampled and the clock back at its idle level, in either polarity
          if (edge_ff == 5'h00 && sck_ff == mode_ff[qspic_pkg::CPOL_BIT])
          begin
            state_ff <= qspic_pkg::POST;
            if (!cmd_w[qspic_pkg::CMD_DT_BIT])
              wait_ff <= 14'(qspic_pkg::STD_POST_CYC);
            else if (dly_ff[7:0] == 8'h00)
              wait_ff <= 14'(qspic_pkg::POST_ZERO_CYC);
            else
              wait_ff <= 14'({dly_ff[7:0], 5'b00000});                 // 32x
          end
        end
        qspic_pkg::POST:
        begin
          if (done_cmd)
          begin
            done_ptr_ff <= qp_ff;
            state_ff    <= qspic_pkg::NEXT;
          end
          wait_ff <= wait_ff - 14'h0001;
        end
        qspic_pkg::NEXT:
        begin
          state_ff <= qspic_pkg::LEAD;
          wait_ff  <= 14'h0000;
          if (stop_req_ff)
            state_ff <= qspic_pkg::IDLE;
          else if (qp_ff == wrap_ff[qspic_pkg::END_LSB +: 4])
          begin
            if (!wrap_ff[qspic_pkg::WRAP_ON_BIT])
              state_ff <= qspic_pkg::IDLE;
            else if (wrap_ff[qspic_pkg::WRAP_TGT_BIT])
              qp_ff <= wrap_ff[qspic_pkg::START_LSB +: 4];
            else
              qp_ff <= 4'h0;
          end
          else
            qp_ff <= qp_ff + 4'h1;
        end
        default:
          state_ff <= qspic_pkg::IDLE;
      endcase
    end
  end

  // serial clock, shifter and data out
  always_ff @(posedge clk_in)
  begin
    if (srst_in || state_ff != qspic_pkg::SHIFT)
    begin
      sck_ff   <= mode_ff[qspic_pkg::CPOL_BIT];
      edge_ff  <= 5'h00;
      if (state_ff == qspic_pkg::LEAD && !srst_in)
      begin
        shreg_ff <= ram_ff[6'(qspic_pkg::TX_BASE) + 6'(qp_ff)] << (5'h10 - nbits);
        edge_ff  <= nbits;
        // phase 0 presents the first bit before the leading edge
        if (!mode_ff[qspic_pkg::CPHA_BIT])
          dout_ff <= ram_ff[6'(qspic_pkg::TX_BASE) + 6'(qp_ff)][4'(nbits - 5'h01)];
      end
      else if (srst_in)
      begin
        shreg_ff <= 16'h0000;
        dout_ff  <= 1'b0;
      end
    end
    else if (half_tick)
    begin
      sck_ff <= !sck_ff;
      // sample edge: the leading edge in phase 0, the trailing edge in phase 1
      if ((sck_ff == mode_ff[qspic_pkg::CPOL_BIT]) != mode_ff[qspic_pkg::CPHA_BIT])
      begin
        shreg_ff <= {shreg_ff[14:0], din_s2_ff};   // sample edge
        if (edge_ff != 5'h00)
          edge_ff <= edge_ff - 5'h01;
      end
      else
        dout_ff <= shreg_ff[15];                   // change edge, next bit always on top
    end
  end

  // select lines and output enable
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      cs_ff        <= 4'h0;
      dout_oe_n_ff <= 1'b0;
    end
    else
    begin
      if (state_ff == qspic_pkg::LEAD || state_ff == qspic_pkg::SHIFT
          || (state_ff == qspic_pkg::POST && cmd_w[qspic_pkg::CMD_CONT_BIT]))
        cs_ff <= cmd_w[3:0];
      else
        cs_ff <= {4{wrap_ff[qspic_pkg::CS_IDLE_BIT]}};
      dout_oe_n_ff <= (state_ff != qspic_pkg::SHIFT) && mode_ff[qspic_pkg::DOUT_TRI_BIT];
    end
  end

  assign pins_out = '{sck: sck_ff, dout: dout_ff, dout_oe_n: dout_oe_n_ff, cs: cs_ff};

endmodule

// file: verif/qspic_ctrl_properties.sv
// checker for the queued serial master control block: apb timing, idle pins and serial clock rate
// assumes one clock and writes that land at the pready edge; bound at the foot
module qspic_ctrl_properties
(
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        din_in,
  input wire logic        abort_lockout_in,
  input wire qspic_pkg::qspic_pins_t pins_out
);
  logic [15:0] mode_ff;  // shadow of the mode register
  logic        select_idle_level_ff;  // shadow of the select idle level
  logic        run_ff;   // run bit as software last left it
  logic [3:0]  quiet_ff; // cycles since the last write
  logic        sck_q_ff; // serial clock one cycle back
  logic [7:0]  gap_ff;   // cycles since the last clock edge
  logic        wr;       // write accepted now
  logic        stopped;  // queue idle and settled
  assign wr = psel_in & penable_in & pwrite_in & pready_out;
  assign stopped = !run_ff && quiet_ff > 4'h3;
  // shadows; a locked-out clear leaves the run bit set
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      mode_ff  <= 16'h0000;
      select_idle_level_ff  <= 1'b0;
      run_ff   <= 1'b0;
      quiet_ff <= 4'hF;
    end
    else
    begin
      quiet_ff <= wr ? 4'h0 : (quiet_ff == 4'hF ? 4'hF : quiet_ff + 4'h1);
      if (wr && paddr_in == qspic_pkg::MODE_OFS) mode_ff <= pwdata_in[15:0];
      if (wr && paddr_in == qspic_pkg::WRAP_OFS) select_idle_level_ff <= pwdata_in[12];
      if (wr && paddr_in == qspic_pkg::DELAY_OFS && (pwdata_in[15] || !abort_lockout_in)) run_ff <= pwdata_in[15];
    end
  end
  // spacing between serial clock edges, saturating
  always_ff @(posedge clk_in)
  begin
    sck_q_ff <= pins_out.sck;
    gap_ff   <= (pins_out.sck != sck_q_ff) ? 8'h01 : (gap_ff == 8'hFF ? 8'hFF : gap_ff + 8'h01);
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  property p_ready; psel_in && !penable_in |=> pready_out; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_pulse; pready_out |=> !pready_out; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_slverr; pready_out |-> pslverr_out == (paddr_in > 8'h10); endproperty
  a_slverr: assert property (p_slverr) else $error("error response wrong");
  property p_sck_idle; stopped |-> pins_out.sck == mode_ff[9]; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock off idle level");
  property p_dout_tri; stopped |-> pins_out.dout_oe_n == mode_ff[14]; endproperty
  a_dout_tri: assert property (p_dout_tri) else $error("data out enable wrong");
  property p_cs_idle; stopped |-> pins_out.cs == {4{select_idle_level_ff}}; endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("selects off idle level");
  property p_baud_off; mode_ff[7:0] == 8'h00 && quiet_ff > 4'h3 |=> $stable(pins_out.sck); endproperty
  a_baud_off: assert property (p_baud_off) else $error("clock runs with zero divider");
  property p_rate; pins_out.sck != sck_q_ff && pins_out.sck == mode_ff[9] && quiet_ff > 4'h3 |-> gap_ff == mode_ff[7:0];
  endproperty
  a_rate: assert property (p_rate) else $error("clock half period wrong");
  c_err: cover property (pready_out && pslverr_out);
  c_edge: cover property (pins_out.sck != sck_q_ff);
  c_tri: cover property (stopped && mode_ff[14]);
endmodule
bind qspic_ctrl qspic_ctrl_properties u_props (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .din_in(din_in), .abort_lockout_in(abort_lockout_in),
  .pins_out(pins_out));

// file: verif/qspic_periph_model.sv
// serial peripheral stand-in: counts clock edges while selected, answers on din
// assumes the select idle level is given and every pin comes from a flop
module qspic_periph_model
(
  input  wire logic       clk_in,
  input  wire logic       clr_in,
  input  wire logic       idle_in,
  input  wire qspic_pkg::qspic_pins_t pins_in,
  output logic            din_out,
  output logic [7:0]      edges_out
);
  logic       sck_q_ff; // clock one cycle back
  logic [3:0] cs_q_ff;  // selects one cycle back
  logic       sel;      // selected now or a cycle ago, so a last edge at deselect counts
  assign sel = pins_in.cs != {4{idle_in}} || cs_q_ff != {4{idle_in}};
  // unselected, din toggles every cycle so a stale bit is never read as valid
  always_ff @(posedge clk_in)
  begin
    sck_q_ff <= pins_in.sck;
    cs_q_ff  <= pins_in.cs;
    if (clr_in)
    begin
      edges_out <= 8'h00;
      din_out   <= 1'b0;
    end
    else
    begin
      if (sel && pins_in.sck != sck_q_ff) edges_out <= edges_out + 8'h01;
      din_out <= sel ? din_out ^ (pins_in.sck != sck_q_ff) : ~din_out;
    end
  end
endmodule

// file: verif/tb.sv
// self-checking bench for the queued serial master control block
// assumes package, design, checker and peripheral model compiled before it
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, srst_in, psel_in, penable_in, pwrite_in, din_in, abort_lockout_in, clr;
  logic [7:0]  paddr_in, edges;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        pready_out, pslverr_out, err;
  int          n_errors, num_checks;
  qspic_pkg::qspic_pins_t pins_out;
  qspic_ctrl dut (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .din_in(din_in), .abort_lockout_in(abort_lockout_in),
    .pins_out(pins_out));
  qspic_periph_model peer (.clk_in(clk_in), .clr_in(clr), .idle_in(1'b1), .pins_in(pins_out), .din_out(din_in),
    .edges_out(edges));
  // system clock, 100 ns period
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    $display("[FAIL] t=%0t timeout", $time);
    complete_run();
  endtask
  // one apb transfer; bits above 15 stay zero since only half-words are legal
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in    <= 1'b1;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= {16'h0000, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1)
    begin
      if (++n > 20) hang();
      @(posedge clk_in);
    end
    rd  = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // reset values, read-only pointer, unmapped place, indirect storage
  task automatic t_regs();
    apb(0, qspic_pkg::MODE_OFS, 16'h0000); chk(rd, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(0, qspic_pkg::DELAY_OFS, 16'h0000); chk(rd, 32'h0);
    apb(0, qspic_pkg::WRAP_OFS, 16'h0000); chk(rd, 32'h0);
    apb(0, 8'h14, 16'h0000); chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1, qspic_pkg::WRAP_OFS, 16'h30F2);
    apb(0, qspic_pkg::WRAP_OFS, 16'h0000); chk(rd, 32'h3002);
    apb(1, qspic_pkg::WRAP_OFS, 16'h1000);
    apb(1, qspic_pkg::RAM_IDX_OFS, 16'h0000);
    apb(1, qspic_pkg::RAM_WIN_OFS, 16'h1234);
    apb(1, qspic_pkg::RAM_WIN_OFS, 16'hBEEF);
    apb(1, qspic_pkg::RAM_IDX_OFS, 16'h0000);
    apb(0, qspic_pkg::RAM_WIN_OFS, 16'h0000); chk(rd, 32'h1234);
    apb(0, qspic_pkg::RAM_WIN_OFS, 16'h0000); chk(rd, 32'hBEEF);
    $display("test regs done");
  endtask
  // poll the run bit until the queue stops by itself
  task automatic wait_stop();
    int n;
    n = 0;
    apb(0, qspic_pkg::DELAY_OFS, 16'h0000);
    while (rd[15] !== 1'b0)
    begin
      if (++n > 1000) hang();
      apb(0, qspic_pkg::DELAY_OFS, 16'h0000);
    end
  endtask
  // one-entry queue: lead delay, bit count, self-clearing run bit
  task automatic run_q(input logic [15:0] mode, input logic [7:0] cmd, input int bits, input int lead);
    int n;
    apb(1, qspic_pkg::MODE_OFS, mode); // master bit set first
    apb(1, qspic_pkg::RAM_IDX_OFS, 16'h0020);
    apb(1, qspic_pkg::RAM_WIN_OFS, {8'h00, cmd});
    clr <= 1'b1;
    apb(1, qspic_pkg::DELAY_OFS, 16'h8500);
    clr <= 1'b0;
    n = 0;
    while (pins_out.cs === 4'hF)
    begin
      if (++n > 50) hang();
      @(posedge clk_in);
    end
    n = 0;
    while (pins_out.sck === mode[9])
    begin
      if (++n > 300) hang();
      @(posedge clk_in);
    end
    chk(32'(n), 32'(lead));
    wait_stop();
    chk(rd, 32'h0500);
    chk({24'h0, edges}, 32'(2 * bits));
    apb(0, qspic_pkg::WRAP_OFS, 16'h0000); chk(rd, 32'h1000);
    $display("test queue done");
  endtask
  // clearing run: refused under lock-out, aborts otherwise
  task automatic t_abort();
    apb(1, qspic_pkg::MODE_OFS, 16'hC0FF);
    apb(1, qspic_pkg::DELAY_OFS, 16'h8500);
    repeat (20) @(posedge clk_in);
    abort_lockout_in <= 1'b1;
    apb(1, qspic_pkg::DELAY_OFS, 16'h0500);
    apb(0, qspic_pkg::DELAY_OFS, 16'h0000); chk(rd, 32'h8500);
    abort_lockout_in <= 1'b0;
    apb(1, qspic_pkg::DELAY_OFS, 16'h0500);
    apb(0, qspic_pkg::DELAY_OFS, 16'h0000); chk(rd, 32'h0500);
    repeat (6) @(posedge clk_in);
    chk({28'h0, pins_out.cs}, 32'hF);
    chk({31'h0, pins_out.dout_oe_n}, 32'h1);
    chk({31'h0, pins_out.sck}, 32'h0);
    $display("test abort done");
  endtask
  // entries 1..2 in phase 1: end pointer stops, then wraparound runs until halt
  task automatic t_wrap();
    apb(1, qspic_pkg::MODE_OFS, 16'h8104); // master bit set first
    apb(1, qspic_pkg::RAM_IDX_OFS, 16'h0021);
    apb(1, qspic_pkg::RAM_WIN_OFS, 16'h001E);
    apb(1, qspic_pkg::RAM_WIN_OFS, 16'h001E);
    apb(1, qspic_pkg::WRAP_OFS, 16'h1201);
    clr <= 1'b1;
    apb(1, qspic_pkg::DELAY_OFS, 16'h8500);
    clr <= 1'b0;
    wait_stop();
    chk({24'h0, edges}, 32'h20);
    apb(0, qspic_pkg::WRAP_OFS, 16'h0000); chk(rd, 32'h1221);
    clr <= 1'b1;
    apb(1, qspic_pkg::WRAP_OFS, 16'h7201);
    apb(1, qspic_pkg::DELAY_OFS, 16'h8500);
    clr <= 1'b0;
    repeat (400) @(posedge clk_in);
    apb(0, qspic_pkg::DELAY_OFS, 16'h0000); chk(rd, 32'h8500);
    apb(1, qspic_pkg::WRAP_OFS, 16'hF201);
    wait_stop();
    chk({28'h0, edges[3:0]}, 32'h0);
    apb(0, qspic_pkg::WRAP_OFS, 16'h0000); chk({31'h0, rd[7:4] == 4'h0}, 32'h0);
    $display("test wrap done");
  endtask
  // reset for 16 cycles, then the scenarios
  initial
  begin
    {srst_in, clr} = 2'b11;
    {psel_in, penable_in, pwrite_in, abort_lockout_in} = 4'h0;
    paddr_in  = 8'h00;
    pwdata_in = 32'h0;
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    clr     <= 1'b0;
    t_regs();
    run_q(16'h8204, 8'h5E, 16, 5);
    run_q(16'hA204, 8'h4E, 8, 4);
    run_q(16'hBC04, 8'h5E, 15, 5);
    run_q(16'hBC04, 8'h1E, 8, 5);
    t_abort();
    t_wrap();
    complete_run();
  end
endmodule
